/* hw/coad_pkg.sv */
// Constants shared by the operand-addressing and flag-update block.
// Assumes an APB master on the CPU clock and byte addresses on paddr.
//
// How it works
// - Eight byte registers numbered 0-7 map X,A,C,B,E,D,L,H in order.
// - Four word pairs 0-3 are AX, BC, DE, HL, built from registers.
// - Short-direct operand reaches FE20H-FF1FH only; its word form is even.
// - Absolute operand spans 0000H-FFFFH; word transfers use even addresses.
// - Call-table operand selects even addresses between 0040H and 007FH.
// - Bit-number operand is three bits choosing one of eight positions.
// - Byte immediates are 8 bits, word immediates 16 bits from the stream.
// - Relative offset is signed 8-bit, sign-extended, then added to PC.
// - Register A is byte accumulator, pair AX the word accumulator.
// - Each pair is reachable as separate high and low bytes.
// - Zero, half carry and carry are each kept, cleared, set, taken from result or restored.
// - Status word holds zero, half carry, carry and interrupt enable flags.
// - A flag stays set while a non-maskable interrupt is being serviced.
// - No interrupt is serviced while flash self-programming runs.
package coad_pkg;
   // Register map, byte addresses on the APB
   localparam logic [7:0] OFF_GPR0 = 8'h00;
   localparam logic [7:0] OFF_PAIR0 = 8'h20;
   localparam logic [7:0] OFF_PSW = 8'h30;
   localparam logic [7:0] OFF_FLAGCMD = 8'h34;
   localparam logic [7:0] OFF_SAVED = 8'h38;
   localparam logic [7:0] OFF_CTRL = 8'h3C;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_OPCMD = 8'h44;
   localparam logic [7:0] OFF_OPRES = 8'h48;
   localparam logic [7:0] OFF_PC = 8'h4C;

   localparam int NUM_GPR = 8;
   localparam int NUM_PAIR = 4;
   localparam int GPR_X = 0;
   localparam int GPR_A = 1;
   localparam logic [7:0] GPR_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;

   // Status word layout
   localparam int PSW_IE = 7;
   localparam int PSW_Z = 6;
   localparam int PSW_AC = 4;
   localparam int PSW_CY = 0;
   localparam logic [7:0] PSW_MASK = 8'hD1;
   localparam logic [7:0] PSW_RST = 8'h00;

   // Operand ranges
   localparam logic [15:0] SADDR_LO = 16'hFE20;
   localparam logic [15:0] SADDR_HI = 16'hFF1F;
   localparam logic [15:0] CALLT_LO = 16'h0040;
   localparam logic [15:0] CALLT_HI = 16'h007F;

   // Operand kinds
   localparam int KIND_W = 4;
   localparam logic [3:0] K_SHORT_B = 4'h0;
   localparam logic [3:0] K_SHORT_W = 4'h1;
   localparam logic [3:0] K_ABS_B = 4'h2;
   localparam logic [3:0] K_ABS_W = 4'h3;
   localparam logic [3:0] K_CALLT = 4'h4;
   localparam logic [3:0] K_REL = 4'h5;
   localparam logic [3:0] K_BIT = 4'h6;
   localparam logic [3:0] K_IMM_B = 4'h7;
   localparam logic [3:0] K_IMM_W = 4'h8;

   // Flag update modes
   localparam logic [2:0] FM_KEEP = 3'h0;
   localparam logic [2:0] FM_CLR = 3'h1;
   localparam logic [2:0] FM_SET = 3'h2;
   localparam logic [2:0] FM_RES = 3'h3;
   localparam logic [2:0] FM_RESTORE = 3'h4;

   // Flag command fields
   localparam int FC_Z_LSB = 0;
   localparam int FC_AC_LSB = 4;
   localparam int FC_CY_LSB = 8;
   localparam int FC_ZRES = 12;
   localparam int FC_ACRES = 13;
   localparam int FC_CYRES = 14;
   localparam int FC_SAVE = 16;

   // Control and status bits
   localparam int CTRL_SELFPROG = 0;
   localparam int CTRL_NMI_END = 1;
   localparam int ST_NMI = 0;
   localparam int ST_SELFPROG = 1;
   localparam int ST_IRQPEND = 2;

   // Operand command and result fields
   localparam int OPC_KIND_LSB = 16;
   localparam int OPR_VALID = 16;
   localparam int OPR_EVEN = 17;
endpackage : coad_pkg

/* hw/coad_operand_decode.sv */
// Operand decoder: bounds and forms the effective operand value.
// Purely combinational; the caller registers whatever it presents.
`timescale 1ns/100ps
`default_nettype none
module coad_operand_decode
   import coad_pkg::*;
(
   input wire logic [3:0] kind,
   input wire logic [15:0] operand,
   input wire logic [15:0] pc,
   output logic [15:0] result,
   output logic inRange,
   output logic evenForced
);
   logic [15:0] evenAddr;
   assign evenAddr = {operand[15:1], 1'b0}; // Low bit dropped on even-only forms

   // Per-kind shaping and range check
   always_comb begin
      result = 16'h0000;
      inRange = 1'b0;
      evenForced = 1'b0;
      unique case (kind)
         K_SHORT_B: begin
            result = operand;
            inRange = (operand >= SADDR_LO) && (operand <= SADDR_HI);
         end
         K_SHORT_W: begin
            result = evenAddr;
            inRange = (evenAddr >= SADDR_LO) && (evenAddr <= SADDR_HI);
            evenForced = operand[0];
         end
         K_ABS_B: begin
            result = operand;
            inRange = 1'b1; // Whole 64K space
         end
         K_ABS_W: begin
            result = evenAddr;
            inRange = 1'b1;
            evenForced = operand[0];
         end
         K_CALLT: begin
            result = evenAddr;
            inRange = (evenAddr >= CALLT_LO) && (evenAddr <= CALLT_HI);
            evenForced = operand[0];
         end
         K_REL: begin
            result = 16'(pc + {{8{operand[7]}}, operand[7:0]});
            inRange = 1'b1;
         end
         K_BIT: begin
            result = {8'h00, 8'(8'h01 << operand[2:0])};
            inRange = (operand[15:3] == 13'h0000);
         end
         K_IMM_B: begin
            result = {8'h00, operand[7:0]};
            inRange = 1'b1;
         end
         K_IMM_W: begin
            result = operand;
            inRange = 1'b1;
         end
         default: begin
            result = 16'h0000; // Unknown kind reads as out of range
            inRange = 1'b0;
         end
      endcase
   end
endmodule : coad_operand_decode
`default_nettype wire

/* hw/coad_core.sv */
// Register file, status word, interrupt gating and operand service.
// Assumes an APB master on clk; interrupt request pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module coad_core
   import coad_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irqReqPin,
   input wire logic nmiReqPin,
   output logic irqAccept,
   output logic nmiAccept,
   output logic [7:0] accByte,
   output logic [15:0] accWord,
   output logic nmiActive,
   output logic selfProgActive
);
   logic [7:0] gpr_q [NUM_GPR];
   logic [7:0] psw_q, savedPsw_q;
   logic [15:0] pc_q;
   logic [19:0] opCmd_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic selfProg_q, nmiActive_q, nmiPend_q;
   logic irqAccept_q, nmiAccept_q;
   logic irqS1_q, irqS2_q, nmiS1_q, nmiS2_q, nmiS3_q;
   logic access, wrEn, rdTake, isGpr, isPair, hit;
   logic [2:0] gprIdx;
   logic [1:0] pairIdx;
   logic [31:0] rdData;
   logic irqTake, nmiTake, nmiEdge, nmiEnd;
   logic [15:0] opResult;
   logic opInRange, opEven;

   // APB phases: one wait state, write lands at the pready edge
   assign access = psel & penable;
   assign wrEn = access & pready_q & pwrite;
   assign rdTake = access & ~pready_q;
   assign isGpr = (paddr[7:5] == OFF_GPR0[7:5]) && (paddr[1:0] == 2'b00);
   assign isPair = (paddr[7:4] == OFF_PAIR0[7:4]) && (paddr[1:0] == 2'b00);
   assign gprIdx = paddr[4:2];
   assign pairIdx = paddr[3:2];
   assign nmiEnd = wrEn && (paddr == OFF_CTRL) && pwdata[CTRL_NMI_END];

   // Read mux and address decode
   always_comb begin
      rdData = 32'h0000_0000;
      hit = 1'b1;
      if (isGpr) begin
         rdData[7:0] = gpr_q[gprIdx];
      end else if (isPair) begin
         rdData[15:0] = {gpr_q[{pairIdx, 1'b1}], gpr_q[{pairIdx, 1'b0}]};
      end else begin
         unique case (paddr)
            OFF_PSW: rdData[7:0] = psw_q;
            OFF_FLAGCMD: rdData = 32'h0000_0000;
            OFF_SAVED: rdData[7:0] = savedPsw_q;
            OFF_CTRL: rdData[CTRL_SELFPROG] = selfProg_q;
            OFF_STATUS: begin
               rdData[ST_NMI] = nmiActive_q;
               rdData[ST_SELFPROG] = selfProg_q;
               rdData[ST_IRQPEND] = irqS2_q;
            end
            OFF_OPCMD: rdData[19:0] = opCmd_q;
            OFF_OPRES: rdData[17:0] = {opEven, opInRange, opResult};
            OFF_PC: rdData[15:0] = pc_q;
            default: hit = 1'b0;
         endcase
      end
   end

   // Bus answer flops; error only for unmapped or misaligned words
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= rdTake;
         pslverr_q <= rdTake & ~hit;
         if (rdTake && !pwrite) begin
            prdata_q <= rdData;
         end
      end
   end

   // General registers; a pair write fills both halves at once
   genvar g;
   generate
      for (g = 0; g < NUM_GPR; g++) begin : gGpr
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               gpr_q[g] <= GPR_RST;
            end else if (ce && wrEn) begin
               if (isGpr && gprIdx == 3'(g)) begin
                  gpr_q[g] <= pwdata[7:0];
               end else if (isPair && pairIdx == 2'(g / 2)) begin
                  gpr_q[g] <= (g % 2 == 1) ? pwdata[15:8] : pwdata[7:0];
               end
            end
         end
      end
   endgenerate

   // Accumulators come straight off the register flops
   assign accByte = gpr_q[GPR_A];
   assign accWord = {gpr_q[GPR_A], gpr_q[GPR_X]};

   // One flag's next value under the five update modes
   function automatic logic flagNext(input logic [2:0] mode, input logic cur,
                                     input logic res, input logic saved);
      logic v;
      v = cur;
      unique case (mode)
         FM_CLR: v = 1'b0;
         FM_SET: v = 1'b1;
         FM_RES: v = res;
         FM_RESTORE: v = saved;
         default: v = cur; // Keep, also for unused codes
      endcase
      return v;
   endfunction : flagNext

   // Status word; an accepted maskable request drops IE last so it wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         psw_q <= PSW_RST;
      end else if (ce) begin
         if (wrEn && paddr == OFF_PSW) begin
            psw_q <= pwdata[7:0] & PSW_MASK;
         end else if (wrEn && paddr == OFF_FLAGCMD) begin
            psw_q[PSW_Z] <= flagNext(pwdata[FC_Z_LSB +: 3], psw_q[PSW_Z],
                                     pwdata[FC_ZRES], savedPsw_q[PSW_Z]);
            psw_q[PSW_AC] <= flagNext(pwdata[FC_AC_LSB +: 3], psw_q[PSW_AC],
                                      pwdata[FC_ACRES], savedPsw_q[PSW_AC]);
            psw_q[PSW_CY] <= flagNext(pwdata[FC_CY_LSB +: 3], psw_q[PSW_CY],
                                      pwdata[FC_CYRES], savedPsw_q[PSW_CY]);
         end
         if (irqTake) begin
            psw_q[PSW_IE] <= 1'b0;
         end
      end
   end

   // Saved copy used by restore; taken on command or on any accept
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         savedPsw_q <= PSW_RST;
      end else if (ce) begin
         if (irqTake || nmiTake) begin
            savedPsw_q <= psw_q;
         end else if (wrEn && paddr == OFF_FLAGCMD && pwdata[FC_SAVE]) begin
            savedPsw_q <= psw_q;
         end
      end
   end

   // Self-programming mode bit; software keeps the clock and staging rules
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         selfProg_q <= 1'b0;
      end else if (ce && wrEn && paddr == OFF_CTRL) begin
         selfProg_q <= pwdata[CTRL_SELFPROG];
      end
   end

   // Operand command and program counter for the relative form
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         opCmd_q <= 20'h0_0000;
         pc_q <= PC_RST;
      end else if (ce && wrEn) begin
         if (paddr == OFF_OPCMD) begin
            opCmd_q <= pwdata[19:0];
         end
         if (paddr == OFF_PC) begin
            pc_q <= pwdata[15:0];
         end
      end
   end

   coad_operand_decode uDecode (
      .kind(opCmd_q[OPC_KIND_LSB +: KIND_W]),
      .operand(opCmd_q[15:0]),
      .pc(pc_q),
      .result(opResult),
      .inRange(opInRange),
      .evenForced(opEven)
   );

   // Pin synchronisers; the first stages feed no logic, the NMI edge uses its last two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqS1_q <= 1'b0;
         irqS2_q <= 1'b0;
         nmiS1_q <= 1'b0;
         nmiS2_q <= 1'b0;
         nmiS3_q <= 1'b0;
      end else if (ce) begin
         irqS1_q <= irqReqPin;
         irqS2_q <= irqS1_q;
         nmiS1_q <= nmiReqPin;
         nmiS2_q <= nmiS1_q;
         nmiS3_q <= nmiS2_q;
      end
   end

   // Acceptance: maskable gated by IE; nothing while self-programming
   assign nmiEdge = nmiS2_q & ~nmiS3_q;
   assign irqTake = irqS2_q & psw_q[PSW_IE] & ~selfProg_q & ~nmiActive_q;
   assign nmiTake = nmiPend_q & ~selfProg_q & ~nmiActive_q;

   // NMI pending holds the edge until it can be serviced; set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nmiPend_q <= 1'b0;
      end else if (ce) begin
         if (nmiEdge) begin
            nmiPend_q <= 1'b1;
         end else if (nmiTake) begin
            nmiPend_q <= 1'b0;
         end
      end
   end

   // Servicing flag: set on accept, cleared at end; set wins the tie
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nmiActive_q <= 1'b0;
      end else if (ce) begin
         if (nmiTake) begin
            nmiActive_q <= 1'b1;
         end else if (nmiEnd) begin
            nmiActive_q <= 1'b0;
         end
      end
   end

   // Accept pulses, one cycle each
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqAccept_q <= 1'b0;
         nmiAccept_q <= 1'b0;
      end else if (ce) begin
         irqAccept_q <= irqTake;
         nmiAccept_q <= nmiTake;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irqAccept = irqAccept_q;
   assign nmiAccept = nmiAccept_q;
   assign nmiActive = nmiActive_q;
   assign selfProgActive = selfProg_q;

   // Checks; frozen cycles are excluded since nothing moves then
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn || !ce);

   a_psw_ie_gate: assert property (irqAccept_q |-> $past(psw_q[PSW_IE]))
      else $error("maskable accept without IE");
   a_selfprog_block: assert property (selfProg_q |=> !irqAccept_q && !nmiAccept_q)
      else $error("interrupt accepted during self-programming");
   a_nmi_flag_set: assert property (nmiAccept_q |-> nmiActive_q)
      else $error("nmi accepted but servicing flag clear");
   a_nmi_flag_end: assert property (nmiEnd && !nmiTake |=> !nmiActive_q)
      else $error("servicing flag not cleared at end");
   a_short_range: assert property (opCmd_q[OPC_KIND_LSB +: KIND_W] == K_SHORT_B && opInRange
      |-> opResult >= SADDR_LO && opResult <= SADDR_HI)
      else $error("short-direct result out of window");
   a_callt_even: assert property (opCmd_q[OPC_KIND_LSB +: KIND_W] == K_CALLT
      |-> !opResult[0] && (!opInRange || opResult <= CALLT_HI))
      else $error("call-table address odd or beyond window");
   a_rel_sext: assert property (opCmd_q[OPC_KIND_LSB +: KIND_W] == K_REL
      |-> opResult == 16'(pc_q + {{8{opCmd_q[7]}}, opCmd_q[7:0]}))
      else $error("relative target not sign extended");
   a_flag_clear: assert property (wrEn && paddr == OFF_FLAGCMD
      && pwdata[FC_CY_LSB +: 3] == FM_CLR |=> !psw_q[PSW_CY])
      else $error("carry not cleared");
   a_flag_set: assert property (wrEn && paddr == OFF_FLAGCMD
      && pwdata[FC_AC_LSB +: 3] == FM_SET |=> psw_q[PSW_AC])
      else $error("half carry flag not set");
   a_pair_write: assert property (wrEn && isPair
      |=> {gpr_q[{$past(pairIdx), 1'b1}], gpr_q[{$past(pairIdx), 1'b0}]}
          == $past(pwdata[15:0]))
      else $error("pair halves not written");
   a_bit_onehot: assert property (opCmd_q[OPC_KIND_LSB +: KIND_W] == K_BIT
      |-> $onehot(opResult[7:0]) && opResult[15:8] == 8'h00)
      else $error("bit select not one-hot");
   a_apb_wait: assert property (rdTake |=> pready_q ##1 !pready_q)
      else $error("apb answer not after one wait");

   c_irq_taken: cover property (irqAccept_q);
   c_nmi_cycle: cover property (nmiAccept_q ##[1:50] !nmiActive_q);
   c_restore: cover property (wrEn && paddr == OFF_FLAGCMD
      && pwdata[FC_CY_LSB +: 3] == FM_RESTORE);
   c_bad_addr: cover property (pslverr_q);
endmodule : coad_core
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for coad_core: APB registers, operand decode,
// flag updates and interrupt gating, through the register bus and the core's output ports.
// Assumes coad_pkg and coad_core compile first; one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import coad_pkg::*;
;
   logic clk, rstn, ce, psel, penable, pwrite, irqReqPin, nmiReqPin;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready, pslverr, irqAccept, nmiAccept, nmiActive, selfProgActive;
   logic [7:0] accByte;
   logic [15:0] accWord;
   int nFail, checksDone, k;
   logic [31:0] rd;
   logic err, seen;
   // Operand table: kind, operand, expected result fields, compare mask
   logic [3:0] tKind [18] = '{K_SHORT_B, K_SHORT_B, K_SHORT_B, K_SHORT_B, K_SHORT_W,
      K_ABS_B, K_ABS_W, K_ABS_B, K_CALLT, K_CALLT, K_CALLT, K_CALLT, K_REL, K_REL,
      K_BIT, K_BIT, K_IMM_B, K_IMM_W};
   logic [15:0] tOp [18] = '{16'hFE20, 16'hFE1F, 16'hFF1F, 16'hFF20, 16'hFE21,
      16'hFFFF, 16'h1235, 16'h0000, 16'h0041, 16'h007E, 16'h003E, 16'h0080,
      16'h0080, 16'h007F, 16'h0005, 16'h0008, 16'h12AB, 16'h12AB};
   logic [31:0] tExp [18] = '{32'h0001_FE20, 32'h0000_0000, 32'h0001_FF1F, 32'h0000_0000,
      32'h0003_FE20, 32'h0001_FFFF, 32'h0003_1234, 32'h0001_0000, 32'h0003_0040,
      32'h0001_007E, 32'h0000_0000, 32'h0000_0000, 32'h0000_0080, 32'h0000_017F,
      32'h0001_0020, 32'h0000_0000, 32'h0000_00AB, 32'h0000_12AB};
   logic [31:0] tMask [18] = '{32'h0003_FFFF, 32'h0001_0000, 32'h0003_FFFF, 32'h0001_0000,
      32'h0003_FFFF, 32'h0003_FFFF, 32'h0003_FFFF, 32'h0003_FFFF, 32'h0003_FFFF,
      32'h0003_FFFF, 32'h0001_0000, 32'h0001_0000, 32'h0000_FFFF, 32'h0000_FFFF,
      32'h0001_FFFF, 32'h0001_0000, 32'h0000_FFFF, 32'h0000_FFFF};
   // Flag commands and the status word each one leaves behind
   logic [31:0] fCmd [4] = '{32'h0001_0000, 32'h0000_0021, 32'h0000_1133, 32'h0000_0444};
   logic [31:0] fExp [4] = '{32'h0000_0051, 32'h0000_0011, 32'h0000_0040, 32'h0000_0051};

   coad_core dut_u (
      .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irqReqPin(irqReqPin),
      .nmiReqPin(nmiReqPin), .irqAccept(irqAccept), .nmiAccept(nmiAccept),
      .accByte(accByte), .accWord(accWord), .nmiActive(nmiActive),
      .selfProgActive(selfProgActive)
   );

   // Free-running CPU clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_bit(input logic got, input logic exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   // One APB transfer; pready and read data are taken at the same edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         nFail++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk_reg(rd, exp);
   endtask : rdc

   // Watch a fixed window for an accept pulse, then compare
   task automatic wait_acc(input logic nmi, input logic exp);
      seen = 1'b0;
      repeat (12) begin
         @(posedge clk);
         if ((nmi ? nmiAccept : irqAccept) === 1'b1) seen = 1'b1;
      end
      chk_bit(seen, exp);
   endtask : wait_acc

   // Main sequence
   initial begin
      nFail = 0;
      checksDone = 0;
      rstn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      irqReqPin = 1'b0;
      nmiReqPin = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      // Reset state
      rdc(OFF_PSW, 32'h0000_0000);
      rdc(OFF_GPR0, 32'h0000_0000);
      chk_reg({16'h0000, accWord}, 32'h0000_0000);
      // Byte registers by number, then as pairs and halves
      for (k = 0; k < NUM_GPR; k++) begin
         apb(1'b1, OFF_GPR0 + 8'(4 * k), {24'hFF_FFFF, 8'(8'hA0 + k)});
      end
      for (k = 0; k < NUM_GPR; k++) begin
         rdc(OFF_GPR0 + 8'(4 * k), 32'(8'hA0 + k));
      end
      for (k = 0; k < NUM_PAIR; k++) begin
         rdc(OFF_PAIR0 + 8'(4 * k), {16'h0000, 8'(8'hA1 + 2 * k), 8'(8'hA0 + 2 * k)});
      end
      chk_reg({24'h00_0000, accByte}, 32'h0000_00A1);
      chk_reg({16'h0000, accWord}, 32'h0000_A1A0);
      apb(1'b1, OFF_PAIR0 + 8'h04, 32'hFFFF_5A3C);
      rdc(OFF_GPR0 + 8'h08, 32'h0000_003C);
      rdc(OFF_GPR0 + 8'h0C, 32'h0000_005A);
      apb(1'b1, OFF_PAIR0, 32'h0000_1234);
      @(negedge clk);
      chk_reg({8'h00, accByte, accWord}, 32'h0012_1234);
      // Unmapped and misaligned places
      apb(1'b0, 8'h50, 32'h0000_0000);
      chk_bit(err, 1'b1);
      chk_reg(rd, 32'h0000_0000);
      apb(1'b1, 8'h02, 32'h0000_00FF);
      chk_bit(err, 1'b1);
      // Status word bits and every flag update mode
      apb(1'b1, OFF_PSW, 32'hFFFF_FFFF);
      rdc(OFF_PSW, 32'h0000_00D1);
      apb(1'b1, OFF_PSW, 32'h0000_0051);
      for (k = 0; k < 4; k++) begin
         apb(1'b1, OFF_FLAGCMD, fCmd[k]);
         rdc(OFF_PSW, fExp[k]);
      end
      rdc(OFF_SAVED, 32'h0000_0051);
      rdc(OFF_FLAGCMD, 32'h0000_0000);
      // Operand bounds, even forcing, offsets and immediates
      apb(1'b1, OFF_PC, 32'h0000_0100);
      rdc(OFF_PC, 32'h0000_0100);
      for (k = 0; k < 18; k++) begin
         apb(1'b1, OFF_OPCMD, {12'h000, tKind[k], tOp[k]});
         apb(1'b0, OFF_OPRES, 32'h0000_0000);
         chk_reg(rd & tMask[k], tExp[k]);
      end
      // Maskable request refused while the enable flag is clear
      apb(1'b1, OFF_PSW, 32'h0000_0000);
      irqReqPin <= 1'b1;
      wait_acc(1'b0, 1'b0);
      // Nothing serviced during self-programming
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      @(posedge clk);
      chk_bit(selfProgActive, 1'b1);
      nmiReqPin <= 1'b1;
      wait_acc(1'b1, 1'b0);
      apb(1'b1, OFF_PSW, 32'h0000_0080);
      wait_acc(1'b0, 1'b0);
      apb(1'b1, OFF_PSW, 32'h0000_0000);
      apb(1'b1, OFF_CTRL, 32'h0000_0000);
      wait_acc(1'b1, 1'b1);
      chk_bit(nmiActive, 1'b1);
      rdc(OFF_STATUS, 32'h0000_0005);
      // Maskable held off until the non-maskable service ends
      apb(1'b1, OFF_PSW, 32'h0000_0080);
      wait_acc(1'b0, 1'b0);
      apb(1'b1, OFF_CTRL, 32'h0000_0002);
      @(negedge clk);
      chk_bit(nmiActive, 1'b0);
      wait_acc(1'b0, 1'b1);
      rdc(OFF_PSW, 32'h0000_0000);
      irqReqPin <= 1'b0;
      nmiReqPin <= 1'b0;
      repeat (4) @(posedge clk);
      // Clock enable low freezes the request path; it resumes once enabled
      ce <= 1'b0;
      nmiReqPin <= 1'b1;
      wait_acc(1'b1, 1'b0);
      ce <= 1'b1;
      wait_acc(1'b1, 1'b1);
      close_out();
   end
endmodule : testbench
`default_nettype wire
